// *** hw/fnsc_pkg.sv ***
package fnsc_pkg;

    localparam int FRAME_CHIPS     = 38400;
    localparam int DOFF_UNIT_CHIPS = 512;
    localparam int CFN_MOD         = 256;
    localparam int ROUND_CHIPS     = 256;
    localparam int CFN_W           = 8;
    localparam int SFN_W           = 12;
    localparam int CHIP_W          = 16;
    localparam int DOFF_P_W        = 10;
    localparam int DOFF_T_W        = 7;
    localparam int PROD_W          = 32;
    localparam logic [CFN_W-1:0]  CFN_ZERO    = 8'h00;
    localparam logic [CFN_W-1:0]  CFN_ONE     = 8'h01;
    localparam logic [CHIP_W-1:0] CHIP_ZERO   = 16'h0000;
    localparam logic [CHIP_W-1:0] CHIP_FRAME  = 16'h9600;
    localparam logic [CHIP_W-1:0] CHIP_HALF_R = 16'h0080;
    localparam logic [CHIP_W-1:0] CHIP_R_MASK = 16'hFF00;

    typedef enum logic [1:0] {
        ST_COMMON    = 2'b00,
        ST_PAGING    = 2'b01,
        ST_DEDICATED = 2'b10
    } fnsc_ue_state_t;

    typedef enum logic [1:0] {
        L1_IDLE = 2'b00,
        L1_PREP = 2'b01,
        L1_WAIT = 2'b10
    } fnsc_l1_state_t;

    // chip sum with carry into the frame count
    function automatic logic [CFN_W+CHIP_W-1:0] fnsc_add_offs(
        input logic [CFN_W-1:0]  fo,
        input logic [CHIP_W-1:0] chip,
        input logic [CFN_W-1:0]  dfo,
        input logic [CHIP_W-1:0] dchip
    );
        logic [CHIP_W:0]    csum;
        logic [CFN_W-1:0]   fsum;
        csum = {1'b0, chip} + {1'b0, dchip};
        fsum = fo + dfo;
        if (csum >= {1'b0, CHIP_FRAME}) begin
            csum = csum - {1'b0, CHIP_FRAME};
            fsum = fsum + CFN_ONE;
        end
        return {fsum, csum[CHIP_W-1:0]};
    endfunction

endpackage

// *** hw/fnsc_offset_calc.sv ***
`timescale 1ns/100ps
module fnsc_offset_calc
    import fnsc_pkg::*;
(
    input  wire logic [fnsc_pkg::DOFF_P_W-1:0] doff,
    output logic [fnsc_pkg::CFN_W-1:0]         frame_offset,
    output logic [fnsc_pkg::CHIP_W-1:0]        chip_offset,
    output logic [fnsc_pkg::CFN_W-1:0]         round_frame_offset,
    output logic [fnsc_pkg::CHIP_W-1:0]        round_chip_offset
);
    logic [PROD_W-1:0] prod;
    logic [PROD_W-1:0] quot;
    logic [PROD_W-1:0] rem;
    logic [CHIP_W-1:0] rsum;

    // frame offset * 38400 + chip offset = default offset * 512
    assign prod         = {{(PROD_W-DOFF_P_W){1'b0}}, doff}
                          * PROD_W'(DOFF_UNIT_CHIPS);
    assign quot         = prod / PROD_W'(FRAME_CHIPS);
    assign rem          = prod % PROD_W'(FRAME_CHIPS);
    assign frame_offset = quot[CFN_W-1:0];
    assign chip_offset  = rem[CHIP_W-1:0];

    // nearest 256-chip boundary, spilling into the next frame
    assign rsum = (chip_offset + CHIP_HALF_R) & CHIP_R_MASK;
    always_comb begin
        if (rsum >= CHIP_FRAME) begin
            round_frame_offset = frame_offset + CFN_ONE;
            round_chip_offset  = CHIP_ZERO;
        end else begin
            round_frame_offset = frame_offset;
            round_chip_offset  = rsum;
        end
    end

endmodule

// *** hw/fnsc_ctrl.sv ***
// Functional notes
// R1: common and paging state channels use frame offset zero.
// R2: paired single link: frame offset*38400 + chip offset = default*512.
// R3: time-division single link: frame offset equals generated default.
// R4: time-division common channels keep frame offset zero when dedicated.
// R5: time-division target offset is reported value, else the default.
// R6: paired hard handover with unknown target uses default-offset relation.
// R7: device loads counter from system frame number in common states.
// R8: paired dedicated entry: counter = (sfn - default*512 div 38400) mod 256.
// R9: time-division dedicated entry: counter = (sfn - default) mod 256.
// R10: time-division common channel counter stays sfn mod 256.
// R11: device reports per-cell offset as (cell sfn - counter) mod 256.
// R12: device initialises counter from reference cell after measurements.
// R13: device reports paired target offset and chip timing offset.
// R14: device reports time-division target offset or substitute value.
// R15: known target offset: no new default sent, counter kept.
// R16: unknown target offset: new default sent before handover.
// R17: prepare base stations, choose switch counter value, all switch then.
// R18: device reports zero offset entering from another system; the terminal model has no such case.
// R19: base station rounds offsets to nearest 256-chip boundary.
// R20: controller may optionally request target offset report when dedicated.
// R21: frame strobe advances counter; a load wins over the increment.
`timescale 1ns/100ps
module fnsc_ctrl
    import fnsc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          frame_tick,
    input  wire logic                          mode_tdd,
    input  wire fnsc_pkg::fnsc_ue_state_t      ue_state,
    input  wire logic [fnsc_pkg::SFN_W-1:0]    system_frame_number,
    input  wire logic [fnsc_pkg::DOFF_P_W-1:0] default_offset_paired,
    input  wire logic [fnsc_pkg::DOFF_T_W-1:0] default_offset_time_division,
    input  wire logic                          setup_req,
    input  wire logic                          ho_req,
    input  wire logic                          ho_off_known,
    input  wire logic [fnsc_pkg::CFN_W-1:0]    ho_off,
    input  wire logic [fnsc_pkg::CHIP_W-1:0]   ho_tm,
    input  wire logic                          ask_target_report,
    input  wire logic                          l1_req,
    input  wire logic [fnsc_pkg::CFN_W-1:0]    l1_margin,
    input  wire logic                          prep_ack,
    output logic [fnsc_pkg::CFN_W-1:0]         common_frame_offset,
    output logic [fnsc_pkg::CFN_W-1:0]         ded_frame_offset,
    output logic [fnsc_pkg::CHIP_W-1:0]        ded_chip_offset,
    output logic [fnsc_pkg::CFN_W-1:0]         bs_frame_offset,
    output logic [fnsc_pkg::CHIP_W-1:0]        bs_chip_offset,
    output logic [fnsc_pkg::DOFF_P_W-1:0]      doff_sent,
    output logic                               setup_done,
    output logic [fnsc_pkg::CFN_W-1:0]         tgt_frame_offset,
    output logic [fnsc_pkg::CHIP_W-1:0]        tgt_chip_offset,
    output logic                               tgt_done,
    output logic                               new_doff_send,
    output logic                               target_report_req,
    output logic [fnsc_pkg::CFN_W-1:0]         connection_frame_number,
    output logic                               prep_cmd,
    output logic [fnsc_pkg::CFN_W-1:0]         switch_cfn,
    output logic                               switch_valid,
    output logic                               l1_apply
);
    import fnsc_pkg::*;

    logic [CFN_W-1:0]        calc_fo;
    logic [CHIP_W-1:0]       calc_chip;
    logic [CFN_W-1:0]        calc_rfo;
    logic [CHIP_W-1:0]       calc_rchip;
    logic [CFN_W-1:0]        tdd_doff;
    logic [CFN_W+CHIP_W-1:0] ho_sum;
    logic [CFN_W-1:0]        cfn_r;
    logic [CFN_W-1:0]        cfn_nxt;
    logic [CFN_W-1:0]        load_fo;
    logic [CFN_W-1:0]        margin;
    logic [CFN_W-1:0]        ded_fo_r;
    logic [CHIP_W-1:0]       ded_chip_r;
    logic [CFN_W-1:0]        bs_fo_r;
    logic [CHIP_W-1:0]       bs_chip_r;
    logic [DOFF_P_W-1:0]     doff_sent_r;
    logic                    setup_done_r;
    logic [CFN_W-1:0]        tgt_fo_r;
    logic [CHIP_W-1:0]       tgt_chip_r;
    logic                    tgt_done_r;
    logic                    new_doff_r;
    logic                    report_req_r;
    logic [CFN_W-1:0]        switch_cfn_r;
    logic                    switch_valid_r;
    logic                    apply_r;
    fnsc_l1_state_t          l1_r;

    fnsc_offset_calc u_calc (
        .doff               (default_offset_paired),
        .frame_offset       (calc_fo),
        .chip_offset        (calc_chip),
        .round_frame_offset (calc_rfo),
        .round_chip_offset  (calc_rchip)
    );

    assign tdd_doff = {{(CFN_W-DOFF_T_W){1'b0}}, default_offset_time_division};
    assign ho_sum   = fnsc_add_offs(ded_fo_r, ded_chip_r, ho_off, ho_tm);

    // R1 zero offset on common channels
    // R4 also while dedicated in time-division
    assign common_frame_offset = CFN_ZERO;

    // single radio link setup on entry to the dedicated state
    always_ff @(posedge clk) begin
        if (rst) begin
            ded_fo_r     <= CFN_ZERO;
            ded_chip_r   <= CHIP_ZERO;
            bs_fo_r      <= CFN_ZERO;
            bs_chip_r    <= CHIP_ZERO;
            doff_sent_r  <= '0;
            setup_done_r <= 1'b0;
        end else begin
            setup_done_r <= setup_req;
            if (setup_req) begin
                if (mode_tdd) begin
                    // R3 frame offset from time-division default
                    ded_fo_r    <= tdd_doff;
                    ded_chip_r  <= CHIP_ZERO;
                    bs_fo_r     <= tdd_doff;
                    bs_chip_r   <= CHIP_ZERO;
                    doff_sent_r <= {{(DOFF_P_W-DOFF_T_W){1'b0}},
                                    default_offset_time_division};
                end else begin
                    // R2 split default offset into frame and chip
                    ded_fo_r    <= calc_fo;
                    ded_chip_r  <= calc_chip;
                    // R19 base station timing on 256-chip grid
                    bs_fo_r     <= calc_rfo;
                    bs_chip_r   <= calc_rchip;
                    doff_sent_r <= default_offset_paired;
                end
            end
        end
    end

    // target cell offsets at link addition or handover
    always_ff @(posedge clk) begin
        if (rst) begin
            tgt_fo_r   <= CFN_ZERO;
            tgt_chip_r <= CHIP_ZERO;
            tgt_done_r <= 1'b0;
            new_doff_r <= 1'b0;
        end else begin
            tgt_done_r <= ho_req;
            // R15 known target needs no new default
            // R16 unknown target gets a new default first
            new_doff_r <= ho_req && !ho_off_known;
            if (ho_req) begin
                if (mode_tdd) begin
                    // R5 reported offset or the default
                    tgt_fo_r   <= ho_off_known ? ho_off : tdd_doff;
                    tgt_chip_r <= CHIP_ZERO;
                end else if (ho_off_known) begin
                    tgt_fo_r   <= ho_sum[CFN_W+CHIP_W-1:CHIP_W];
                    tgt_chip_r <= ho_sum[CHIP_W-1:0];
                end else begin
                    // R6 fall back to the single-link relation
                    tgt_fo_r   <= calc_fo;
                    tgt_chip_r <= calc_chip;
                end
            end
        end
    end

    // R20 optional request for a target offset report
    always_ff @(posedge clk) begin
        if (rst) begin
            report_req_r <= 1'b0;
        end else begin
            report_req_r <= ask_target_report && (ue_state == ST_DEDICATED);
        end
    end

    // network copy of the counter, mirroring the terminal's
    assign load_fo = mode_tdd ? tdd_doff : calc_fo;
    always_comb begin
        cfn_nxt = cfn_r;
        if (ue_state != ST_DEDICATED) begin
            // R7 follows the system frame number
            cfn_nxt = system_frame_number[CFN_W-1:0];
        end else if (setup_req) begin
            // R8 load wins over the increment
            cfn_nxt = system_frame_number[CFN_W-1:0] - load_fo;
        end else if (frame_tick) begin
            cfn_nxt = cfn_r + CFN_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfn_r <= CFN_ZERO;
        end else begin
            cfn_r <= cfn_nxt;
        end
    end

    // synchronised layer-1 change
    assign margin = (l1_margin == CFN_ZERO) ? CFN_ONE : l1_margin;
    always_ff @(posedge clk) begin
        if (rst) begin
            l1_r           <= L1_IDLE;
            switch_cfn_r   <= CFN_ZERO;
            switch_valid_r <= 1'b0;
            apply_r        <= 1'b0;
        end else begin
            switch_valid_r <= 1'b0;
            apply_r        <= 1'b0;
            unique case (l1_r)
                L1_IDLE: begin
                    if (l1_req) begin
                        l1_r <= L1_PREP;
                    end
                end
                L1_PREP: begin
                    // R17 switch value chosen after preparation
                    if (prep_ack) begin
                        switch_cfn_r   <= cfn_r + margin;
                        switch_valid_r <= 1'b1;
                        l1_r           <= L1_WAIT;
                    end
                end
                L1_WAIT: begin
                    // R17 apply at the agreed counter value
                    if (!switch_valid_r && cfn_r == switch_cfn_r) begin
                        apply_r <= 1'b1;
                        l1_r    <= L1_IDLE;
                    end
                end
                default: begin
                    l1_r <= L1_IDLE;
                end
            endcase
        end
    end

    assign ded_frame_offset        = ded_fo_r;
    assign ded_chip_offset         = ded_chip_r;
    assign bs_frame_offset         = bs_fo_r;
    assign bs_chip_offset          = bs_chip_r;
    assign doff_sent               = doff_sent_r;
    assign setup_done              = setup_done_r;
    assign tgt_frame_offset        = tgt_fo_r;
    assign tgt_chip_offset         = tgt_chip_r;
    assign tgt_done                = tgt_done_r;
    assign new_doff_send           = new_doff_r;
    assign target_report_req       = report_req_r;
    assign connection_frame_number = cfn_r;
    assign prep_cmd                = (l1_r == L1_PREP);
    assign switch_cfn              = switch_cfn_r;
    assign switch_valid            = switch_valid_r;
    assign l1_apply                = apply_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_prep_done;
        prep_cmd && prep_ack;
    endsequence

    sequence s_switch_told;
        switch_valid && !prep_cmd;
    endsequence

    a_common_offset_zero: assert property ( // R1
        (ue_state != ST_DEDICATED || mode_tdd) |-> common_frame_offset == 0)
        else $error("common channel frame offset not zero");

    a_paired_setup_sum: assert property ( // R2
        setup_req && !mode_tdd |=>
        32'(ded_fo_r) * 32'(FRAME_CHIPS) + 32'(ded_chip_r)
            == 32'($past(default_offset_paired)) * 32'(DOFF_UNIT_CHIPS))
        else $error("paired setup offsets break default relation");

    a_tdd_setup_offset: assert property ( // R3
        setup_req && mode_tdd |=> setup_done && ded_fo_r == $past(tdd_doff)
        && ded_chip_r == 0)
        else $error("time-division setup offset wrong");

    a_tdd_target_offset: assert property ( // R5
        ho_req && mode_tdd |=> tgt_done && tgt_fo_r ==
        ($past(ho_off_known) ? $past(ho_off) : $past(tdd_doff)))
        else $error("time-division target offset wrong");

    a_paired_unknown_tgt: assert property ( // R6
        ho_req && !mode_tdd && !ho_off_known |=>
        32'(tgt_fo_r) * 32'(FRAME_CHIPS) + 32'(tgt_chip_r)
            == 32'($past(default_offset_paired)) * 32'(DOFF_UNIT_CHIPS))
        else $error("unknown paired target ignores default relation");

    a_known_no_doff: assert property ( // R15
        ho_req && ho_off_known |=> !new_doff_send)
        else $error("default offset sent for known target");

    a_unknown_sends_doff: assert property ( // R16
        ho_req && !ho_off_known |=> new_doff_send && tgt_done)
        else $error("no default offset sent for unknown target");

    a_switch_after_prep: assert property ( // R17
        s_prep_done |=> s_switch_told ##0 switch_cfn == $past(cfn_r)
        + $past(margin))
        else $error("switch value not issued after preparation");

    a_apply_at_cfn: assert property ( // R17
        l1_apply |-> $past(cfn_r) == switch_cfn && !prep_cmd)
        else $error("layer-1 change applied at wrong counter");

    a_round_chip_grid: assert property ( // R19
        $rose(setup_done) |-> bs_chip_offset[7:0] == 8'h00
        && bs_chip_offset < CHIP_FRAME)
        else $error("base station chip offset off the grid");

    a_report_only_ded: assert property ( // R20
        target_report_req |-> $past(ue_state) == ST_DEDICATED)
        else $error("target report requested outside dedicated state");

endmodule

// *** test/fnsc_term_model.sv ***
`timescale 1ns/100ps
module fnsc_term_model
    import fnsc_pkg::*;
#(
    parameter logic [fnsc_pkg::CFN_W-1:0]  SUBST_OFF = 8'hFF,
    parameter logic [fnsc_pkg::CHIP_W-1:0] MEAS_TM   = 16'h0200
)
(
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          frame_tick,
    input  wire logic                          mode_tdd,
    input  wire fnsc_pkg::fnsc_ue_state_t      ue_state,
    input  wire logic [fnsc_pkg::SFN_W-1:0]    system_frame_number,
    input  wire logic [fnsc_pkg::DOFF_P_W-1:0] doff_p,
    input  wire logic [fnsc_pkg::DOFF_T_W-1:0] doff_t,
    input  wire logic                          init_req,
    input  wire logic [fnsc_pkg::SFN_W-1:0]    sfn_target,
    input  wire logic                          tgt_measurable,
    input  wire logic [fnsc_pkg::CFN_W-1:0]    switch_cfn,
    input  wire logic                          switch_valid,
    output logic [fnsc_pkg::CFN_W-1:0]         cfn_r,
    output logic [fnsc_pkg::SFN_W-1:0]         paging_cfn_r,
    output logic [fnsc_pkg::CFN_W-1:0]         common_cfn,
    output logic [fnsc_pkg::CFN_W-1:0]         rep_off,
    output logic [fnsc_pkg::CHIP_W-1:0]        rep_tm,
    output logic                               apply_r
);
    logic [PROD_W-1:0] prod;
    logic [PROD_W-1:0] quot;
    logic [CFN_W-1:0]  init_val;
    logic              armed_r;

    assign prod = PROD_W'(doff_p) * DOFF_UNIT_CHIPS;
    assign quot = prod / FRAME_CHIPS;
    // dedicated entry: sfn minus the time-division default or the paired frame offset
    assign init_val = mode_tdd ? system_frame_number[CFN_W-1:0] - {1'b0, doff_t}
                               : system_frame_number[CFN_W-1:0] - quot[CFN_W-1:0];
    // common channels keep the cell count
    assign common_cfn = system_frame_number[CFN_W-1:0];
    assign rep_off = tgt_measurable ? sfn_target[CFN_W-1:0] - cfn_r
                                    : SUBST_OFF;
    assign rep_tm  = mode_tdd ? CHIP_ZERO : MEAS_TM;

    // load wins over the frame step
    always_ff @(posedge clk) begin
        if (rst) begin
            cfn_r        <= CFN_ZERO;
            paging_cfn_r <= '0;
        end else if (ue_state != ST_DEDICATED) begin
            cfn_r        <= system_frame_number[CFN_W-1:0];
            paging_cfn_r <= system_frame_number;
        end else if (init_req) begin
            cfn_r <= init_val;
        end else if (frame_tick) begin
            cfn_r <= cfn_r + CFN_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            armed_r <= 1'b0;
            apply_r <= 1'b0;
        end else begin
            apply_r <= armed_r && cfn_r == switch_cfn;
            if (switch_valid) begin
                armed_r <= 1'b1;
            end else if (armed_r && cfn_r == switch_cfn) begin
                armed_r <= 1'b0;
            end
        end
    end
endmodule

// *** test/frame_number_sync_counters_tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
end
module frame_number_sync_counters_tb;
    import fnsc_pkg::*;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                frame_tick, mode_tdd, setup_req, ho_req;
    logic                ask_target_report, l1_req, prep_ack;
    logic                init_req, tgt_meas, setup_done, tgt_done;
    logic                new_doff_send, target_report_req, prep_cmd;
    logic                switch_valid, l1_apply, m_apply;
    fnsc_ue_state_t      ue_state;
    logic [SFN_W-1:0]    system_frame_number, sfn_tgt, m_paging;
    logic [DOFF_P_W-1:0] default_offset_paired, doff_sent;
    logic [DOFF_T_W-1:0] default_offset_time_division;
    logic [CFN_W-1:0]    l1_margin, ho_off, common_frame_offset;
    logic [CFN_W-1:0]    ded_frame_offset, bs_frame_offset, switch_cfn;
    logic [CFN_W-1:0]    tgt_frame_offset, connection_frame_number;
    logic [CFN_W-1:0]    m_cfn, m_common, exp_cnt;
    logic [CHIP_W-1:0]   ho_tm, ded_chip_offset, bs_chip_offset;
    logic [CHIP_W-1:0]   tgt_chip_offset;
    logic [9:0]          dps [4] = '{10'h000, 10'h04B, 10'h04C, 10'h3FF};
    int                  err_count = 0;
    int                  num_checks = 0;

    always #12.5 clk = ~clk;

    fnsc_ctrl u_fnsc_ctrl (
        .clk, .rst, .frame_tick, .mode_tdd, .ue_state, .system_frame_number,
        .default_offset_paired, .default_offset_time_division, .setup_req,
        .ho_req, .ho_off_known(tgt_meas), .ho_off, .ho_tm,
        .ask_target_report, .l1_req, .l1_margin, .prep_ack,
        .common_frame_offset, .ded_frame_offset, .ded_chip_offset,
        .bs_frame_offset, .bs_chip_offset, .doff_sent, .setup_done,
        .tgt_frame_offset, .tgt_chip_offset, .tgt_done, .new_doff_send,
        .target_report_req, .connection_frame_number, .prep_cmd,
        .switch_cfn, .switch_valid, .l1_apply
    );

    // chip timing chosen so a known paired target carries into the frame
    fnsc_term_model #(.MEAS_TM(16'h3E80)) u_fnsc_term_model (
        .clk, .rst, .frame_tick, .mode_tdd, .ue_state, .system_frame_number,
        .doff_p(default_offset_paired),
        .doff_t(default_offset_time_division),
        .init_req, .sfn_target(sfn_tgt), .tgt_measurable(tgt_meas),
        .switch_cfn, .switch_valid, .cfn_r(m_cfn), .paging_cfn_r(m_paging),
        .common_cfn(m_common), .rep_off(ho_off), .rep_tm(ho_tm),
        .apply_r(m_apply)
    );

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic pulse_frame();
        frame_tick = 1'b1;
        tick();
        frame_tick = 1'b0;
        tick();
        exp_cnt = exp_cnt + 8'h01;
    endtask

    task automatic run_setup(input logic ft, input logic tdd,
        input logic [9:0] dp, input logic [6:0] dt);
        logic [31:0] prod;
        logic [7:0]  fo;
        logic [15:0] ch;
        prod = 32'(dp) * DOFF_UNIT_CHIPS;
        fo = tdd ? {1'b0, dt} : 8'(prod / FRAME_CHIPS);
        ch = tdd ? CHIP_ZERO : 16'(prod % FRAME_CHIPS);
        {mode_tdd, frame_tick, setup_req, init_req} = {tdd, ft, 2'b11};
        default_offset_paired = dp;
        default_offset_time_division = dt;
        ue_state = ST_DEDICATED;
        tick();
        {frame_tick, setup_req, init_req} = 3'b000;
        exp_cnt = system_frame_number[7:0] - fo;
        `CHK("setup_done", 1'b1, setup_done)
        `CHK("ded_frame_offset", fo, ded_frame_offset)
        `CHK("ded_chip_offset", ch, ded_chip_offset)
        `CHK("common_frame_offset", 8'h00, common_frame_offset)
        `CHK("cfn", exp_cnt, connection_frame_number)
        `CHK("terminal cfn", exp_cnt, m_cfn)
        if (!tdd) begin
            `CHK("bs_frame_offset", fo, bs_frame_offset)
            `CHK("bs_chip_offset", ch, bs_chip_offset)
            `CHK("doff_sent", dp, doff_sent)
        end else begin
            `CHK("doff_sent", {3'b000, dt}, doff_sent)
        end
        tick();
        `CHK("setup_done", 1'b0, setup_done)
    endtask

    task automatic run_ho(input logic known, input logic [11:0] st,
        input logic [7:0] efo, input logic [15:0] ech);
        tgt_meas = known;
        sfn_tgt = st;
        ho_req = 1'b1;
        tick();
        ho_req = 1'b0;
        `CHK("tgt_done", 1'b1, tgt_done)
        `CHK("new_doff_send", !known, new_doff_send)
        `CHK("tgt_frame_offset", efo, tgt_frame_offset)
        `CHK("tgt_chip_offset", ech, tgt_chip_offset)
        `CHK("cfn", exp_cnt, connection_frame_number)
        tick();
        `CHK("tgt_done", 1'b0, tgt_done)
    endtask

    task automatic run_l1(input logic [7:0] m);
        logic [7:0] sw;
        int         n;
        l1_req = 1'b1;
        tick();
        l1_req = 1'b0;
        repeat (2) tick();
        `CHK("prep_cmd", 1'b1, prep_cmd)
        {prep_ack, l1_margin} = {1'b1, m};
        tick();
        prep_ack = 1'b0;
        n = (m == 8'h00) ? 1 : int'(m);
        sw = exp_cnt + 8'(n);
        `CHK("switch_valid", 1'b1, switch_valid)
        `CHK("prep_cmd", 1'b0, prep_cmd)
        `CHK("switch_cfn", sw, switch_cfn)
        repeat (n) pulse_frame();
        for (int i = 0; i < 8 && l1_apply !== 1'b1; i++) tick();
        `CHK("l1_apply", 1'b1, l1_apply)
        `CHK("terminal apply", 1'b1, m_apply)
        `CHK("cfn", sw, connection_frame_number)
        if (l1_apply !== 1'b1) final_report();
        tick();
        `CHK("l1_apply", 1'b0, l1_apply)
    endtask

    initial begin
        {frame_tick, mode_tdd, setup_req, ho_req, ask_target_report} = '0;
        {l1_req, prep_ack, init_req, tgt_meas} = '0;
        {system_frame_number, sfn_tgt, l1_margin} = '0;
        {default_offset_paired, default_offset_time_division} = '0;
        ue_state = ST_COMMON;
        repeat (12) tick();
        rst = 1'b0;
        `CHK("common_frame_offset", 8'h00, common_frame_offset)
        `CHK("prep_cmd", 1'b0, prep_cmd)
        $display("reset test done");
        ue_state = ST_PAGING;
        system_frame_number = 12'h1A5;
        repeat (2) tick();
        `CHK("cfn", 8'hA5, connection_frame_number)
        `CHK("paging cfn", 12'h1A5, m_paging)
        `CHK("common cfn", 8'hA5, m_common)
        $display("common state test done");
        system_frame_number = 12'h123;
        foreach (dps[i]) run_setup(1'b0, 1'b0, dps[i], 7'h00);
        $display("paired setup test done");
        // own offsets 0x0D frames and 0x6000 chips plus reported offsets
        run_ho(1'b1, 12'h050, 8'h50 - exp_cnt + 8'h0E, 16'h0880);
        run_ho(1'b0, 12'h050, 8'h0D, 16'h6000);
        $display("paired handover test done");
        system_frame_number = 12'h0FF;
        run_setup(1'b0, 1'b1, 10'h000, 7'h01);
        repeat (3) pulse_frame();
        `CHK("cfn", exp_cnt, connection_frame_number)
        `CHK("terminal cfn", exp_cnt, m_cfn)
        run_setup(1'b1, 1'b1, 10'h000, 7'h64);
        `CHK("common cfn", 8'hFF, m_common)
        $display("counter test done");
        run_ho(1'b1, 12'h3C0, 8'hC0 - exp_cnt, 16'h0000);
        run_ho(1'b0, 12'h3C0, 8'h64, 16'h0000);
        $display("time-division handover test done");
        run_l1(8'h00);
        run_l1(8'h03);
        $display("layer-1 change test done");
        ask_target_report = 1'b1;
        repeat (2) tick();
        `CHK("target_report_req", 1'b1, target_report_req)
        ue_state = ST_COMMON;
        repeat (2) tick();
        `CHK("target_report_req", 1'b0, target_report_req)
        $display("report request test done");
        final_report();
    end
endmodule
